/* src/txo_overlay.sv */
`timescale 1ns/1ps
// What this block does
// - Manual or automatic alarm forces all ones on the NRZ line output and alternate marks on the dual-rail pins.
// - All-ones alarm also overrides line loopback receive data.
// - Automatic alarm lasts exactly while receive signal loss is asserted.
// - Manual alarm with switching on picks alternate clock; auto never.
// - Framer loopback data is never altered by alarm transmission.
// - Switching on, manual off: clock loss gives ones on alternate clock.
// - Test pattern generated only while the generator enable bit 4 is set.
// - Framed T1: generator pauses on the frame bit every 193 bits.
// - Framed E1: skip timeslot 0, and timeslot 16 when CAS selected.
// - Unframed: pattern fills every timeslot including framing positions.
// - Pattern select picks PRBS 2^11, 2^15, 2^20 or 2^23.
// - Zero limit allows 7 zeros for short patterns, 14 for long.
// - Invert 2^15 and 2^23 unless zero limit is on.
// - Code length field gives 4, 5, 6 or 7 bits.
// - Unframed code option lets the code overwrite framing bits.
// - Loopback code sent only while its start bit is set.
// - Code pattern sent from bit 7 downward, reaching bit 1 only for a 7-bit code.
// - All Sa buffer bits sampled once per 16-frame multiframe boundary.
// - Sa bit n goes in timeslot 0 of odd frame 2n+1.
// - Sa frame numbering locked to the transmit CRC multiframe.
module txo_overlay
   import txo_pkg::*;
(
   // System clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [8:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Alarm controls and status, asynchronous
   input wire logic manual_alarm_all_ones_i,
   input wire logic auto_alarm_all_ones_i,
   input wire logic alt_clock_switch_enable_i,
   input wire logic rx_signal_loss_i,
   input wire logic tx_clock_loss_i,
   // Line clocks
   input wire logic tx_line_clock_in_i,
   input wire logic alternate_clock_in_i,
   output logic tx_line_clock_out_o,
   // Framer side, on the transmit line clock
   input wire logic e1_mode_i,
   input wire logic [3:0] tx_frame_mode_i,
   input wire logic line_loopback_i,
   input wire logic tx_multiframe_event_i,
   input wire logic tx_data_i,
   input wire logic rx_loop_data_i,
   output logic framer_loop_data_o,
   // Line side
   output logic line_nrz_out_o,
   output logic line_pos_out_o,
   output logic line_neg_out_o,
   // Status
   output logic ais_active_o,
   output logic alt_clock_active_o
);

   // ---------------- Register port, system clock ----------------
   logic [7:0] patt_q, lbcfg_q, lbpat_q;
   logic [7:0] sa_q [TXO_SA_BYTES];
   logic cfg_tgl_q;

   function automatic int sa_index(input logic [8:0] a);
      sa_index = int'(a - TXO_OFF_SA4);
   endfunction : sa_index

   function automatic logic is_sa(input logic [8:0] a);
      is_sa = (a >= TXO_OFF_SA4) && (a <= TXO_OFF_SA7);
   endfunction : is_sa

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         patt_q <= TXO_REG_RESET;
         lbcfg_q <= TXO_REG_RESET;
         lbpat_q <= TXO_REG_RESET;
         for (int i = 0; i < TXO_SA_BYTES; i++) begin
            sa_q[i] <= TXO_REG_RESET;
         end
      end else if (reg_wr_i) begin
         // Reserved bits are held at zero
         unique case (reg_addr_i)
            TXO_OFF_PATT_CFG: patt_q <= reg_wdata_i & TXO_PATT_MASK;
            TXO_OFF_LB_CFG: lbcfg_q <= reg_wdata_i & TXO_LB_CFG_MASK;
            TXO_OFF_LB_PAT: lbpat_q <= reg_wdata_i & TXO_LB_PAT_MASK;
            default: begin
               if (is_sa(reg_addr_i)) begin
                  sa_q[sa_index(reg_addr_i)] <= reg_wdata_i;
               end
            end
         endcase
      end
   end

   // Any write announces new settings to the line side
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_tgl_q <= 1'b0;
      end else if (reg_wr_i) begin
         cfg_tgl_q <= ~cfg_tgl_q;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= TXO_REG_RESET;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            TXO_OFF_PATT_CFG: reg_rdata_o <= patt_q;
            TXO_OFF_LB_CFG: reg_rdata_o <= lbcfg_q;
            TXO_OFF_LB_PAT: reg_rdata_o <= lbpat_q;
            default: begin
               reg_rdata_o <= is_sa(reg_addr_i) ?
                  sa_q[sa_index(reg_addr_i)] : TXO_REG_RESET;
            end
         endcase
      end
   end

   // ---------------- Alarm and clock decision, system clock ----------------
   logic [4:0] alm_s1_q, alm_s2_q;
   logic man_s, auto_s, sw_s, rls_s, tx_clock_loss_s;
   logic ais_q, alt_sel_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alm_s1_q <= '0;
         alm_s2_q <= '0;
      end else begin
         alm_s1_q <= {manual_alarm_all_ones_i, auto_alarm_all_ones_i,
                      alt_clock_switch_enable_i, rx_signal_loss_i,
                      tx_clock_loss_i};
         alm_s2_q <= alm_s1_q;
      end
   end

   assign {man_s, auto_s, sw_s, rls_s, tx_clock_loss_s} = alm_s2_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ais_q <= 1'b0;
         alt_sel_q <= 1'b0;
      end else begin
         ais_q <= man_s | (auto_s & rls_s) | (sw_s & tx_clock_loss_s);
         alt_sel_q <= sw_s & (man_s | tx_clock_loss_s);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ais_active_o <= 1'b0;
         alt_clock_active_o <= 1'b0;
      end else begin
         ais_active_o <= ais_q;
         alt_clock_active_o <= alt_sel_q;
      end
   end

   a_auto_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      auto_s && !man_s && !sw_s |=> ais_q == $past(rls_s))
      else $error("automatic alarm does not follow signal loss");

   a_auto_noswitch: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      !man_s && !tx_clock_loss_s |=> !alt_sel_q)
      else $error("clock switched without manual alarm or clock loss");

   a_manual_switch: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      sw_s && man_s |=> alt_sel_q && ais_q)
      else $error("manual alarm did not take the alternate clock");

   a_tx_clock_loss_alt: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      sw_s && tx_clock_loss_s |=> alt_sel_q && ais_q)
      else $error("clock loss did not give alarm on alternate clock");

   // ---------------- Transmit clock selection ----------------
   logic tx_clk;
   // Plain mux; with switching on, manual alarm or clock loss selects the alternate clock
   assign tx_clk = alt_sel_q ? alternate_clock_in_i : tx_line_clock_in_i;
   assign tx_line_clock_out_o = tx_clk;

   // ---------------- Crossings into the line domain ----------------
   logic ais_s1_q, ais_l_q;
   logic [2:0] tgl_s_q;
   logic [7:0] patt_l, lbcfg_l, lbpat_l;
   logic [7:0] sa_l [TXO_SA_BYTES];
   logic [7:0] sa_cur [TXO_SA_BYTES];

   always_ff @(posedge tx_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ais_s1_q <= 1'b0;
         ais_l_q <= 1'b0;
         tgl_s_q <= '0;
      end else begin
         ais_s1_q <= ais_q;
         ais_l_q <= ais_s1_q;
         tgl_s_q <= {tgl_s_q[1:0], cfg_tgl_q};
      end
   end

   // Register values are stable by the time the toggle arrives
   always_ff @(posedge tx_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         patt_l <= TXO_REG_RESET;
         lbcfg_l <= TXO_REG_RESET;
         lbpat_l <= TXO_REG_RESET;
         for (int i = 0; i < TXO_SA_BYTES; i++) begin
            sa_l[i] <= TXO_REG_RESET;
         end
      end else if (tgl_s_q[2] != tgl_s_q[1]) begin
         patt_l <= patt_q;
         lbcfg_l <= lbcfg_q;
         lbpat_l <= lbpat_q;
         for (int i = 0; i < TXO_SA_BYTES; i++) begin
            sa_l[i] <= sa_q[i];
         end
      end
   end

   // ---------------- Frame position ----------------
   logic [7:0] bit_q, pos;
   logic [3:0] frame_q, frame;
   logic frame_end, fbit_slot, ts16_slot, sa_slot, sa_bit;

   assign pos = tx_multiframe_event_i ? '0 : bit_q;
   assign frame = tx_multiframe_event_i ? '0 : frame_q;
   assign frame_end = e1_mode_i ? (pos == 8'hff) : (pos == TXO_T1_LAST_BIT);

   always_ff @(posedge tx_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_q <= '0;
         frame_q <= '0;
      end else begin
         bit_q <= frame_end ? '0 : pos + 8'h01;
         frame_q <= frame_end ? frame + 4'h1 : frame;
      end
   end

   assign fbit_slot = e1_mode_i ? (pos < TXO_E1_TS_BITS) : (pos == '0);
   assign ts16_slot = e1_mode_i && tx_frame_mode_i[TXO_CAS_BIT] &&
      (pos >= TXO_E1_TS16_POS) &&
      (pos < TXO_E1_TS16_POS + TXO_E1_TS_BITS);
   assign sa_slot = e1_mode_i && frame[0] && (pos >= TXO_SA_FIRST_POS) &&
      (pos < TXO_SA_FIRST_POS + 8'(TXO_SA_BYTES));
   assign sa_bit = sa_cur[2'(pos - TXO_SA_FIRST_POS)][frame[3:1]];

   // Whole Sa set taken at the multiframe start
   always_ff @(posedge tx_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < TXO_SA_BYTES; i++) begin
            sa_cur[i] <= TXO_REG_RESET;
         end
      end else if (tx_multiframe_event_i) begin
         for (int i = 0; i < TXO_SA_BYTES; i++) begin
            sa_cur[i] <= sa_l[i];
         end
      end
   end

   // ---------------- PRBS generator ----------------
   logic [22:0] lfsr_q;
   logic [3:0] zrun_q, zlim;
   logic gen_on, prbs_slot, fb, raw, prbs_bit, zl;
   txo_patt_t psel;

   assign psel = txo_patt_t'(patt_l[TXO_PSEL_LSB +: 2]);
   assign zl = patt_l[TXO_ZLIM_BIT];
   assign gen_on = patt_l[TXO_GEN_EN_BIT];
   assign prbs_slot = gen_on && !(patt_l[TXO_FRAMED_BIT] &&
      (fbit_slot || ts16_slot));

   always_comb begin
      unique case (psel)
         TXO_PRBS_11: begin
            fb = lfsr_q[10] ^ lfsr_q[8];
            raw = lfsr_q[10];
         end
         TXO_PRBS_15: begin
            fb = lfsr_q[14] ^ lfsr_q[13];
            raw = lfsr_q[14];
         end
         TXO_PRBS_20: begin
            fb = lfsr_q[19] ^ lfsr_q[16];
            raw = lfsr_q[19];
         end
         TXO_PRBS_23: begin
            fb = lfsr_q[22] ^ lfsr_q[17];
            raw = lfsr_q[22];
         end
      endcase
   end

   assign zlim = psel[1] ? TXO_ZLIM_LONG : TXO_ZLIM_SHORT;
   always_comb begin
      if (zl) begin
         prbs_bit = raw | (zrun_q >= zlim);
      end else begin
         prbs_bit = raw ^ psel[0];
      end
   end

   always_ff @(posedge tx_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lfsr_q <= '1;
         zrun_q <= '0;
      end else if (prbs_slot) begin
         // Never let the register lock up at zero
         lfsr_q <= (lfsr_q == '0) ? '1 : {lfsr_q[21:0], fb};
         zrun_q <= prbs_bit ? '0 : zrun_q + 4'h1;
      end
   end

   a_zero_limit: assert property (@(posedge tx_clk) disable iff (!rst_n_i)
      prbs_slot && zl |-> zrun_q <= zlim)
      else $error("zero run exceeds limit");

   // ---------------- Inband loopback code ----------------
   logic [2:0] cidx_q, clen;
   logic code_slot, code_bit;

   assign clen = TXO_LB_MIN_LEN +
      {1'b0, lbcfg_l[TXO_LOOP_CODE_LENGTH_LSB +: 2]};
   assign code_slot = lbcfg_l[TXO_LB_START_BIT] &&
      (lbcfg_l[TXO_LB_UNFR_BIT] || !fbit_slot);
   assign code_bit = lbpat_l[TXO_LB_FIRST_BIT - int'(cidx_q)];

   always_ff @(posedge tx_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cidx_q <= '0;
      end else if (!lbcfg_l[TXO_LB_START_BIT]) begin
         cidx_q <= '0;
      end else if (code_slot) begin
         cidx_q <= (cidx_q + 3'h1 >= clen) ? '0 : cidx_q + 3'h1;
      end
   end

   // ---------------- Output selection ----------------
   logic payload, line_bit, pol_q;

   always_comb begin
      if (code_slot) begin
         payload = code_bit;
      end else if (prbs_slot) begin
         payload = prbs_bit;
      end else if (sa_slot) begin
         payload = sa_bit;
      end else begin
         payload = tx_data_i;
      end
   end

   assign line_bit = ais_l_q ? 1'b1 :
      (line_loopback_i ? rx_loop_data_i : payload);

   always_ff @(posedge tx_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         framer_loop_data_o <= 1'b0;
      end else begin
         framer_loop_data_o <= payload;
      end
   end

   // Alternate mark inversion for the dual-rail pins
   always_ff @(posedge tx_clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_nrz_out_o <= 1'b0;
         line_pos_out_o <= 1'b0;
         line_neg_out_o <= 1'b0;
         pol_q <= 1'b0;
      end else begin
         line_nrz_out_o <= line_bit;
         line_pos_out_o <= line_bit & ~pol_q;
         line_neg_out_o <= line_bit & pol_q;
         pol_q <= pol_q ^ line_bit;
      end
   end

   a_ais_ones: assert property (@(posedge tx_clk) disable iff (!rst_n_i)
      ais_l_q |=> line_nrz_out_o && (line_pos_out_o != line_neg_out_o))
      else $error("alarm did not send all ones");

   a_ais_line_loopback: assert property (@(posedge tx_clk) disable iff (!rst_n_i)
      ais_l_q && line_loopback_i && !rx_loop_data_i |=> line_nrz_out_o)
      else $error("loopback data not overridden by alarm");

   a_framer_loopback_clean: assert property (@(posedge tx_clk) disable iff (!rst_n_i)
      ais_l_q && !code_slot && !prbs_slot && !sa_slot
      |=> framer_loop_data_o == $past(tx_data_i))
      else $error("alarm disturbed framer loopback data");

   a_framed_pause: assert property (@(posedge tx_clk) disable iff (!rst_n_i)
      patt_l[TXO_FRAMED_BIT] && fbit_slot && !code_slot && !sa_slot
      |=> framer_loop_data_o == $past(tx_data_i))
      else $error("pattern overwrote the frame bit");

   a_code_first: assert property (@(posedge tx_clk) disable iff (!rst_n_i)
      code_slot && cidx_q == '0 |=>
      framer_loop_data_o == $past(lbpat_l[TXO_LB_FIRST_BIT]))
      else $error("code does not start with bit 7");

   a_sa_insert: assert property (@(posedge tx_clk) disable iff (!rst_n_i)
      sa_slot && !code_slot && !prbs_slot
      |=> framer_loop_data_o == $past(sa_bit))
      else $error("Sa bit not inserted");

endmodule : txo_overlay

/* src/txo_pkg.sv */
package txo_pkg;

   // Register map of the transmit maintenance overlay
   localparam logic [8:0] TXO_OFF_PATT_CFG = 9'h076;
   localparam logic [8:0] TXO_OFF_LB_CFG = 9'h077;
   localparam logic [8:0] TXO_OFF_LB_PAT = 9'h078;
   localparam logic [8:0] TXO_OFF_SA4 = 9'h07b;
   localparam logic [8:0] TXO_OFF_SA5 = 9'h07c;
   localparam logic [8:0] TXO_OFF_SA6 = 9'h07d;
   localparam logic [8:0] TXO_OFF_SA7 = 9'h07e;
   localparam logic [7:0] TXO_REG_RESET = 8'h00;

   // Test pattern configuration fields
   localparam int TXO_PSEL_LSB = 0;
   localparam int TXO_ZLIM_BIT = 2;
   localparam int TXO_FRAMED_BIT = 3;
   localparam int TXO_GEN_EN_BIT = 4;
   localparam logic [7:0] TXO_PATT_MASK = 8'h1f;

   // Loopback code configuration fields
   localparam int TXO_LB_START_BIT = 0;
   localparam int TXO_LB_UNFR_BIT = 1;
   localparam int TXO_LOOP_CODE_LENGTH_LSB = 2;
   localparam logic [7:0] TXO_LB_CFG_MASK = 8'h0f;
   localparam logic [7:0] TXO_LB_PAT_MASK = 8'hfe;
   localparam logic [2:0] TXO_LB_MIN_LEN = 3'h4;
   localparam int TXO_LB_FIRST_BIT = 7;

   // Frame geometry
   localparam logic [7:0] TXO_T1_LAST_BIT = 8'hc0;
   localparam logic [7:0] TXO_E1_TS_BITS = 8'h08;
   localparam logic [7:0] TXO_E1_TS16_POS = 8'h80;
   localparam int TXO_CAS_BIT = 3;
   localparam logic [7:0] TXO_SA_FIRST_POS = 8'h03;
   localparam int TXO_SA_BYTES = 4;

   // Zero run limits
   localparam logic [3:0] TXO_ZLIM_SHORT = 4'h7;
   localparam logic [3:0] TXO_ZLIM_LONG = 4'he;

   typedef enum logic [1:0] {
      TXO_PRBS_11 = 2'b00,
      TXO_PRBS_15 = 2'b01,
      TXO_PRBS_20 = 2'b10,
      TXO_PRBS_23 = 2'b11
   } txo_patt_t;

endpackage : txo_pkg

/* verif/tx_alarm_test_pattern_overlay_bench.sv */
`timescale 1ns/1ps
module tx_alarm_test_pattern_overlay_bench;
   import txo_pkg::*;
   typedef struct packed {
      logic [8:0] a;
      logic [7:0] w;
      logic [7:0] e;
   } txo_reg_row_t;
   typedef struct packed {
      logic [4:0] in;
      logic ais;
      logic alt;
   } txo_alm_row_t;

   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [8:0] reg_addr_i = '0;
   logic [7:0] reg_wdata_i = '0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic man = 1'b0, aut = 1'b0, swe = 1'b0, rxl = 1'b0, tcl = 1'b0;
   logic e1 = 1'b0, line_loopback = 1'b1, txd = 1'b1, rxd = 1'b0;
   logic [3:0] fmode = 4'h8;
   logic line_clk, alt_clk, clk_out, mf_ev, fl_data;
   logic line_nrz_out_o, line_pos_out_o, line_neg_out_o;
   logic ais_active_o, alt_clock_active_o;
   logic [127:0] ts0;
   int fail_count = 0;
   int checked = 0;
   logic [7:0] sa [4] = '{8'h01, 8'h82, 8'h5a, 8'hc3};

   // Address, write value, read-back value
   txo_reg_row_t regs [9] = '{
      {9'h076, 8'hff, 8'h1f}, {9'h077, 8'hff, 8'h0f},
      {9'h078, 8'hff, 8'hfe}, {9'h07b, 8'ha5, 8'ha5},
      {9'h07c, 8'h5a, 8'h5a}, {9'h07d, 8'h3c, 8'h3c},
      {9'h07e, 8'hc3, 8'hc3}, {9'h079, 8'hff, 8'h00},
      {9'h1ff, 8'hff, 8'h00}};
   // Manual, auto, switch, rx loss, clock loss; then ais, alt
   txo_alm_row_t alm [8] = '{
      {5'h03, 1'b0, 1'b0}, {5'h10, 1'b1, 1'b0}, {5'h14, 1'b1, 1'b1},
      {5'h0a, 1'b1, 1'b0}, {5'h0e, 1'b1, 1'b0}, {5'h09, 1'b0, 1'b0},
      {5'h05, 1'b1, 1'b1}, {5'h0c, 1'b0, 1'b0}};

   always #10 ref_clk_i = ~ref_clk_i;

   txo_overlay dut (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .manual_alarm_all_ones_i(man), .auto_alarm_all_ones_i(aut),
      .alt_clock_switch_enable_i(swe), .rx_signal_loss_i(rxl),
      .tx_clock_loss_i(tcl), .tx_line_clock_in_i(line_clk),
      .alternate_clock_in_i(alt_clk), .tx_line_clock_out_o(clk_out),
      .e1_mode_i(e1), .tx_frame_mode_i(fmode), .line_loopback_i(line_loopback),
      .tx_multiframe_event_i(mf_ev), .tx_data_i(txd),
      .rx_loop_data_i(rxd), .framer_loop_data_o(fl_data),
      .line_nrz_out_o(line_nrz_out_o), .line_pos_out_o(line_pos_out_o),
      .line_neg_out_o(line_neg_out_o), .ais_active_o(ais_active_o),
      .alt_clock_active_o(alt_clock_active_o));

   txo_line_model u_line (
      .line_clk_o(line_clk), .alt_clk_o(alt_clk), .e1_mode_i(e1),
      .clk_out_i(clk_out), .nrz_i(line_nrz_out_o),
      .mf_event_o(mf_ev), .ts0_o(ts0));

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge ref_clk_i);
      d = reg_rdata_o;
   endtask : rd

   // Ones and longest zero run over n line bits
   task automatic scan(input int n, output int ones, output int zr);
      int r;
      ones = 0;
      zr = 0;
      r = 0;
      repeat (n) begin
         @(posedge clk_out);
         if (line_nrz_out_o === 1'b1) begin
            ones++;
            r = 0;
         end else begin
            r++;
            if (r > zr)
               zr = r;
         end
      end
   endtask : scan

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   initial begin
      #500_000;
      fail_count++;
      give_verdict();
   end

   initial begin
      int ones;
      int zr;
      int bad;
      logic [7:0] v;
      logic [20:0] cb;
      logic [127:0] ex;
      repeat (20) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      foreach (regs[i]) begin
         rd(regs[i].a, v);
         chk("reset value", TXO_REG_RESET, v);
         wr(regs[i].a, regs[i].w);
         rd(regs[i].a, v);
         chk("register", regs[i].e, v);
         wr(regs[i].a, 8'h00);
      end
      foreach (alm[i]) begin
         @(posedge ref_clk_i);
         {man, aut, swe, rxl, tcl} <= alm[i].in;
         repeat (12) @(posedge ref_clk_i);
         chk("ais", {7'h00, alm[i].ais}, {7'h00, ais_active_o});
         chk("alt", {7'h00, alm[i].alt}, {7'h00, alt_clock_active_o});
         scan(64, ones, zr);
         chk("line ones", alm[i].ais ? 8'h40 : 8'h00, 8'(ones));
         chk("ami rails", {7'h00, alm[i].ais},
             {7'h00, line_pos_out_o ^ line_neg_out_o});
         chk("framer loop", 8'h01, {7'h00, fl_data});
         bad = 0;
         #0.5;
         repeat (10) begin
            #1.3;
            if (clk_out !== (alm[i].alt ? alt_clk : line_clk))
               bad++;
         end
         chk("clock source", 8'h00, 8'(bad));
      end
      @(posedge ref_clk_i);
      {man, aut, swe, rxl, tcl} <= 5'h00;
      line_loopback <= 1'b0;
      txd <= 1'b0;
      for (int p = 0; p < 4; p++) begin
         wr(TXO_OFF_PATT_CFG, 8'h14 | 8'(p));
         repeat (12) @(posedge ref_clk_i);
         scan(800, ones, zr);
         chk("zero run", 8'h01,
             {7'h00, zr <= (p < 2 ? 7 : 14) && ones > 0});
      end
      wr(TXO_OFF_PATT_CFG, 8'h04);
      repeat (12) @(posedge ref_clk_i);
      scan(200, ones, zr);
      chk("pattern off", 8'h00, 8'(ones));
      wr(TXO_OFF_LB_PAT, 8'h80);
      for (int l = 0; l < 4; l++) begin
         wr(TXO_OFF_LB_CFG, 8'(l * 4 + 3));
         repeat (12) @(posedge ref_clk_i);
         for (int k = 0; k < 21; k++) begin
            @(posedge clk_out);
            cb[k] = line_nrz_out_o;
         end
         bad = 0;
         ones = 0;
         for (int k = 0; k < 17 - l; k++)
            if (cb[k] !== cb[k + l + 4])
               bad++;
         for (int k = 0; k < l + 4; k++)
            if (cb[k] === 1'b1)
               ones++;
         chk("code period", 8'h00, 8'(bad));
         chk("code ones", 8'h01, 8'(ones));
      end
      wr(TXO_OFF_LB_CFG, 8'h02);
      repeat (12) @(posedge ref_clk_i);
      scan(100, ones, zr);
      chk("code stopped", 8'h00, 8'(ones));
      e1 <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         if (r == 1)
            @(posedge mf_ev);
         for (int k = 0; k < 4; k++)
            wr(TXO_OFF_SA4 + 9'(k), sa[k] ^ {8{r[0]}});
         repeat (9000) @(posedge clk_out);
         ex = '0;
         for (int n = 0; n < 8; n++)
            for (int k = 0; k < 4; k++)
               ex[(2 * n + 1) * 8 + 3 + k] = sa[k][n] ^ r[0];
         for (int f = 0; f < 16; f++)
            chk("sa frame", ex[f * 8 +: 8], ts0[f * 8 +: 8]);
      end
      // Framed pattern must leave timeslot 0 to Sa and framer data
      wr(TXO_OFF_PATT_CFG, 8'h18);
      repeat (4400) @(posedge clk_out);
      for (int f = 0; f < 16; f++)
         chk("framed ts0", ex[f * 8 +: 8], ts0[f * 8 +: 8]);
      @(posedge ref_clk_i);
      man <= 1'b1;
      wr(TXO_OFF_PATT_CFG, 8'h10);
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (20) @(posedge ref_clk_i);
      chk("reset ais", 8'h00, {7'h00, ais_active_o});
      chk("reset line", 8'h00, {6'h00, line_nrz_out_o, line_pos_out_o});
      man <= 1'b0;
      rst_n_i <= 1'b1;
      rd(TXO_OFF_PATT_CFG, v);
      chk("cleared cfg", TXO_REG_RESET, v);
      give_verdict();
   end
endmodule : tx_alarm_test_pattern_overlay_bench

/* verif/txo_line_model.sv */
`timescale 1ns/1ps
module txo_line_model (
   // Clocks toward the overlay
   output logic line_clk_o,
   output logic alt_clk_o,
   // Line side of the overlay
   input wire logic e1_mode_i,
   input wire logic clk_out_i,
   input wire logic nrz_i,
   // Framing and capture
   output logic mf_event_o,
   output logic [127:0] ts0_o
);
   logic [11:0] pos_q;
   logic [11:0] prev_q;

   initial begin
      line_clk_o = 1'b0;
      alt_clk_o = 1'b0;
      pos_q = 12'h000;
      prev_q = 12'h000;
      ts0_o = '0;
   end

   always #3 line_clk_o = ~line_clk_o;
   always #4.1 alt_clk_o = ~alt_clk_o;

   // Marks bit 0 of frame 0 of each 16-frame multiframe
   assign mf_event_o = (pos_q == 12'h000);

   // Output bit seen one edge after its position was offered
   always @(posedge clk_out_i) begin
      prev_q <= pos_q;
      if (pos_q == (e1_mode_i ? 12'hfff : 12'hc0f))
         pos_q <= 12'h000;
      else
         pos_q <= pos_q + 12'h001;
      if (e1_mode_i && prev_q[7:3] == 5'h00)
         ts0_o[{prev_q[11:8], prev_q[2:0]}] <= nrz_i;
   end
endmodule : txo_line_model
